//--- logic/fgpio_top.sv
// Purpose: Five-pin general-purpose port with a debug trace output mux.
// Assumes: Plain strobe bus on i_clk (200 MHz); read data one cycle later.
// Notes:   Pads are modelled as level in, level out and active-low enable.
`timescale 1ns/10ps
`default_nettype none
module fgpio_top
  import fgpio_pkg::*;
(
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_b,
  input  wire logic [fgpio_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [fgpio_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output var  logic [fgpio_pkg::DATA_W-1:0]  o_rdata,
  input  wire logic                          i_trace_clock_out,
  input  wire logic [3:0]                    i_trace_data_out,
  input  wire logic [fgpio_pkg::PIN_CNT-1:0] i_pin,
  output var  logic [fgpio_pkg::PIN_CNT-1:0] o_pin,
  output var  logic [fgpio_pkg::PIN_CNT-1:0] o_pin_oe_b,
  output var  logic [fgpio_pkg::PIN_CNT-1:0] o_pullup_bits,
  output var  logic [fgpio_pkg::PIN_CNT-1:0] o_input_enable_bits
);

  logic [PIN_CNT-1:0] pin_data_bits_r;
  fgpio_cfg_type      cfg_r;
  logic [PIN_CNT-1:0] pin_sync;
  logic [PIN_CNT-1:0] pin_gated;
  logic [PIN_CNT-1:0] data_view;
  logic [PIN_CNT-1:0] trace_val;
  logic [DATA_W-1:0]  rdata_nxt;
  logic               hit_data;
  logic               hit_oe;
  logic               hit_fsel;
  logic               hit_od;
  logic               hit_pup;
  logic               hit_ie;

  // Address decode, shared by the write and read paths.
  always_comb begin
    hit_data = (i_addr == OFS_PIN_DATA);
    hit_oe   = (i_addr == OFS_OUT_EN);
    hit_fsel = (i_addr == OFS_FUNC_SEL);
    hit_od   = (i_addr == OFS_OPEN_DRN);
    hit_pup  = (i_addr == OFS_PULLUP_EN);
    hit_ie   = (i_addr == OFS_INPUT_EN);
  end

  // Pin data latch; only the low five bits of a write are kept.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_data_bits_r <= RST_PIN_DATA;
    end else if (i_wr && hit_data) begin
      pin_data_bits_r <= i_wdata[PIN_CNT-1:0];
    end
  end

  // Direction control, one enable per pin.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r.out_en <= RST_OUT_EN;
    end else if (i_wr && hit_oe) begin
      cfg_r.out_en <= i_wdata[PIN_CNT-1:0];
    end
  end

  // Function select decides port use or trace use for each pin.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r.func_sel <= RST_FUNC_SEL;
    end else if (i_wr && hit_fsel) begin
      cfg_r.func_sel <= i_wdata[PIN_CNT-1:0];
    end
  end

  // Output stage type, CMOS or open drain per pin.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r.open_drn <= RST_OPEN_DRN;
    end else if (i_wr && hit_od) begin
      cfg_r.open_drn <= i_wdata[PIN_CNT-1:0];
    end
  end

  // Pull-up enables go to the pads untouched.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r.pullup_en <= RST_PULLUP_EN;
    end else if (i_wr && hit_pup) begin
      cfg_r.pullup_en <= i_wdata[PIN_CNT-1:0];
    end
  end

  // Input buffer enables; a disabled buffer gates its pad level to zero.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r.input_en <= RST_INPUT_EN;
    end else if (i_wr && hit_ie) begin
      cfg_r.input_en <= i_wdata[PIN_CNT-1:0];
    end
  end

  // Pull-up and input enable outputs are the register bits themselves.
  always_comb begin
    o_pullup_bits       = cfg_r.pullup_en;
    o_input_enable_bits = cfg_r.input_en;
  end

  // Pad levels arrive asynchronously and are synchronised first.
  fgpio_sync u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_level (i_pin),
    .o_level (pin_sync)
  );

  // Trace signals already run on i_clk, so they need no synchroniser.
  always_comb begin
    trace_val = {i_trace_data_out[3:1], i_trace_data_out[0],
                 i_trace_clock_out};
  end

  // Output drivers for all five pins.
  fgpio_pad u_pad (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_cfg       (cfg_r),
    .i_port_val  (pin_data_bits_r),
    .i_trace_val (trace_val),
    .o_pin       (o_pin),
    .o_pin_oe_b  (o_pin_oe_b)
  );

  // A pin with its output enable set reads back its latch, so a write is seen at once;
  // an input pin reads its level, and a dead buffer falls back to the latch
  // so the data bit still behaves as plain read/write storage.
  always_comb begin
    pin_gated = pin_sync & cfg_r.input_en;
    data_view = (cfg_r.out_en & pin_data_bits_r)
              | (~cfg_r.out_en & cfg_r.input_en & pin_gated)
              | (~cfg_r.out_en & ~cfg_r.input_en & pin_data_bits_r);
  end

  // Read mux; unmapped offsets answer zero.
  always_comb begin
    rdata_nxt = RDATA_IDLE;
    if (i_rd) begin
      unique case (1'b1)
        hit_data: rdata_nxt = fgpio_widen(data_view);
        hit_oe:   rdata_nxt = fgpio_widen(cfg_r.out_en);
        hit_fsel: rdata_nxt = fgpio_widen(cfg_r.func_sel);
        hit_od:   rdata_nxt = fgpio_widen(cfg_r.open_drn);
        hit_pup:  rdata_nxt = fgpio_widen(cfg_r.pullup_en);
        hit_ie:   rdata_nxt = fgpio_widen(cfg_r.input_en);
        default:  rdata_nxt = RDATA_IDLE;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= RDATA_IDLE;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

  // Read data is zero whenever no read was made the cycle before.
  chk_rdata_idle_zero: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !$past(i_rd) |-> (o_rdata == RDATA_IDLE))
    else $error("read data not zero outside a read answer");

  // Upper bits of every answer stay zero.
  chk_upper_bits_zero: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_rdata[DATA_W-1:PIN_CNT] == '0)
    else $error("upper read data bits not zero");

  // A data write shows on pin 2 while it is a driving CMOS port pin.
  chk_data_write_pin: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && hit_data) ##1 (cfg_r.out_en[2] && !cfg_r.func_sel[2]
      && !cfg_r.open_drn[2])
    |=> (o_pin[2] == $past(pin_data_bits_r[2], 1)) && !o_pin_oe_b[2])
    else $error("data write not seen on driving pin");

  // Output enable write reads back at offset 0x04.
  chk_oe_readback: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && hit_oe) ##1 (i_rd && hit_oe)
    |=> o_rdata[PIN_CNT-1:0] == $past(i_wdata[PIN_CNT-1:0], 2))
    else $error("output enable readback mismatch");

  // A port pin with its driver off never drives.
  chk_port_released: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    ((~$past(cfg_r.out_en) & ~$past(cfg_r.func_sel) & ~o_pin_oe_b) == '0))
    else $error("pin driven with output disabled");

  // An open-drain pin is never driven high.
  chk_open_drain_low: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    ((~o_pin_oe_b & o_pin & $past(cfg_r.open_drn)) == '0))
    else $error("open-drain pin driven high");

  // Trace clock selected on pin 0 follows the trace source one cycle later.
  chk_trace_clock_mux: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (cfg_r.func_sel[POS_TRACE_CLK] && !cfg_r.open_drn[POS_TRACE_CLK])
    |=> (o_pin[POS_TRACE_CLK] == $past(i_trace_clock_out))
        && !o_pin_oe_b[POS_TRACE_CLK])
    else $error("trace clock not routed to pin 0");

  // Trace data 0 selected on pin 1 follows its source.
  chk_trace_data_mux: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (cfg_r.func_sel[POS_TRACE_D0] && !cfg_r.open_drn[POS_TRACE_D0])
    |=> o_pin[POS_TRACE_D0] == $past(i_trace_data_out[0]))
    else $error("trace data 0 not routed to pin 1");

  // Pull-up write reaches the pad enables on the next cycle.
  chk_pullup_follow: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && hit_pup) |=> o_pullup_bits == $past(i_wdata[PIN_CNT-1:0]))
    else $error("pull-up enables did not follow write");

  // Input enable write reaches the pad enables on the next cycle.
  chk_input_en_follow: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && hit_ie) |=> o_input_enable_bits == $past(i_wdata[PIN_CNT-1:0]))
    else $error("input enables did not follow write");

  // Right after reset every pin is released with pull and input off.
  chk_reset_quiet: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> (o_pin_oe_b == '1) && (o_pullup_bits == '0)
      && (o_input_enable_bits == '0))
    else $error("pins not quiet after reset");

  // A pin data write lands in the latch next cycle, low bits only.
  chk_data_latch_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && hit_data) |=> pin_data_bits_r == $past(i_wdata[PIN_CNT-1:0]))
    else $error("pin data write not latched");

  // An output enable write lands in the direction control next cycle.
  chk_oe_write_lands: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && hit_oe) |=> cfg_r.out_en == $past(i_wdata[PIN_CNT-1:0]))
    else $error("output enable write not latched");

  // Function select written and read in the next cycle returns the written field.
  chk_fsel_readback: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && hit_fsel) ##1 (i_rd && hit_fsel)
    |=> o_rdata[PIN_CNT-1:0] == $past(i_wdata[PIN_CNT-1:0], 2))
    else $error("function select readback mismatch");

  // Open-drain select written and read in the next cycle returns the written field.
  chk_od_readback: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && hit_od) ##1 (i_rd && hit_od)
    |=> o_rdata[PIN_CNT-1:0] == $past(i_wdata[PIN_CNT-1:0], 2))
    else $error("open-drain readback mismatch");

  // A read of an unmapped offset answers zero.
  chk_unmapped_zero: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_rd && !(hit_data || hit_oe || hit_fsel)
      && !(hit_od || hit_pup || hit_ie)
    |=> o_rdata == RDATA_IDLE)
    else $error("unmapped read not zero");

  // An input pin with its buffer on reads its synchronised level.
  chk_input_read: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_rd && hit_data) |=> ((o_rdata[PIN_CNT-1:0] ^ $past(pin_sync))
      & $past(~cfg_r.out_en & cfg_r.input_en)) == '0)
    else $error("input pin level not read back");

  // A trace pin with a CMOS stage always drives.
  chk_trace_drives: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (($past(cfg_r.func_sel) & ~$past(cfg_r.open_drn) & o_pin_oe_b) == '0))
    else $error("trace pin not driven");

  // A CMOS port pin with its driver on shows the latch one cycle later.
  chk_port_drives: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    ((($past(pin_data_bits_r) ^ o_pin) | o_pin_oe_b)
      & $past(cfg_r.out_en & ~cfg_r.func_sel & ~cfg_r.open_drn)) == '0)
    else $error("port pin not driving its latch");

endmodule
`default_nettype wire

//--- logic/fgpio_pkg.sv
// Purpose: Shared constants and types for the five-pin port block.
// Assumes: Byte addresses on a plain strobe bus, 32-bit data words.
// Notes:   Every offset, bus width and control-field reset value is named here once.
`default_nettype none
package fgpio_pkg;

  // Port geometry and bus widths.
  localparam int unsigned PIN_CNT = 5;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;

  // Register byte offsets from the block base.
  localparam logic [ADDR_W-1:0] OFS_PIN_DATA  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_EN    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FUNC_SEL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OPEN_DRN  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PULLUP_EN = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_INPUT_EN  = 8'h38;

  // Reset values of the control fields.
  localparam logic [PIN_CNT-1:0] RST_PIN_DATA  = 5'h00;
  localparam logic [PIN_CNT-1:0] RST_OUT_EN    = 5'h00;
  localparam logic [PIN_CNT-1:0] RST_FUNC_SEL  = 5'h00;
  localparam logic [PIN_CNT-1:0] RST_OPEN_DRN  = 5'h00;
  localparam logic [PIN_CNT-1:0] RST_PULLUP_EN = 5'h00;
  localparam logic [PIN_CNT-1:0] RST_INPUT_EN  = 5'h00;

  // Pin positions of the trace signals in the function select field.
  localparam int unsigned POS_TRACE_CLK = 0;
  localparam int unsigned POS_TRACE_D0  = 1;

  // Read data before the live field is placed in the low bits.
  localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

  // Pad configuration that travels from the register file to the drivers.
  typedef struct packed {
    logic [PIN_CNT-1:0] out_en;
    logic [PIN_CNT-1:0] func_sel;
    logic [PIN_CNT-1:0] open_drn;
    logic [PIN_CNT-1:0] pullup_en;
    logic [PIN_CNT-1:0] input_en;
  } fgpio_cfg_type;

  // Zero-extend a pin field into a bus word; upper bits always read zero.
  function automatic logic [DATA_W-1:0] fgpio_widen(
    input logic [PIN_CNT-1:0] field
  );
    fgpio_widen = {{(DATA_W-PIN_CNT){1'b0}}, field};
  endfunction

endpackage
`default_nettype wire

//--- logic/fgpio_sync.sv
// Purpose: Two-stage synchroniser for the pad input levels.
// Assumes: Pad levels change with no relation to i_clk.
// Notes:   Only the second stage is visible to the rest of the block.
`timescale 1ns/10ps
`default_nettype none
module fgpio_sync
  import fgpio_pkg::*;
(
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_b,
  input  wire logic [fgpio_pkg::PIN_CNT-1:0] i_level,
  output var  logic [fgpio_pkg::PIN_CNT-1:0] o_level
);

  logic [PIN_CNT-1:0] meta_r;

  // First stage feeds only the second, so no logic sees a metastable value.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r  <= '0;
      o_level <= '0;
    end else begin
      meta_r  <= i_level;
      o_level <= meta_r;
    end
  end

endmodule
`default_nettype wire

//--- logic/fgpio_pad.sv
// Purpose: Registered output drivers for the five port pins.
// Assumes: Configuration and data come from flops on the same clock.
// Notes:   Output enable is active low; a released pin floats or pulls up.
`timescale 1ns/10ps
`default_nettype none
module fgpio_pad
  import fgpio_pkg::*;
(
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_b,
  input  wire fgpio_pkg::fgpio_cfg_type      i_cfg,
  input  wire logic [fgpio_pkg::PIN_CNT-1:0] i_port_val,
  input  wire logic [fgpio_pkg::PIN_CNT-1:0] i_trace_val,
  output var  logic [fgpio_pkg::PIN_CNT-1:0] o_pin,
  output var  logic [fgpio_pkg::PIN_CNT-1:0] o_pin_oe_b
);

  logic [PIN_CNT-1:0] val_nxt;
  logic [PIN_CNT-1:0] drive_nxt;

  // Trace use overrides the port latch and always wants the driver.
  always_comb begin
    val_nxt   = (i_cfg.func_sel & i_trace_val)
              | (~i_cfg.func_sel & i_port_val);
    drive_nxt = i_cfg.func_sel | i_cfg.out_en;
    // An open-drain pin only ever pulls low; a one releases it.
    drive_nxt = drive_nxt & ~(i_cfg.open_drn & val_nxt);
  end

  // Pins come straight from flops so no glitch reaches the pads.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin      <= '0;
      o_pin_oe_b <= '1;
    end else begin
      o_pin      <= val_nxt;
      o_pin_oe_b <= ~drive_nxt;
    end
  end

endmodule
`default_nettype wire

//--- dv/fgpio_pins_model.sv
// Purpose: Board-side model of the five pads and an external driver.
// Assumes: Bench gives the external drive value and enable per pin.
// Notes:   A pad nobody holds toggles each cycle so it cannot read stable.
`timescale 1ns/10ps
`default_nettype none
module fgpio_pins_model
  import fgpio_pkg::*;
(
  input  wire logic                          i_clk,
  input  wire logic [fgpio_pkg::PIN_CNT-1:0] i_pin_out,
  input  wire logic [fgpio_pkg::PIN_CNT-1:0] i_pin_oe_b,
  input  wire logic [fgpio_pkg::PIN_CNT-1:0] i_pullup,
  input  wire logic [fgpio_pkg::PIN_CNT-1:0] i_ext_val,
  input  wire logic [fgpio_pkg::PIN_CNT-1:0] i_ext_en,
  output var  logic [fgpio_pkg::PIN_CNT-1:0] o_level
);
  logic [PIN_CNT-1:0] float_r = 5'h0a;

  // Floating pads change every cycle; a simulator zero would hide faults.
  always_ff @(posedge i_clk) begin
    float_r <= ~float_r;
  end

  // Active-low enable drives; else external; else pull-up; else float.
  always_comb begin
    for (int i = 0; i < PIN_CNT; i++) begin
      if (!i_pin_oe_b[i]) begin
        o_level[i] = i_pin_out[i];
      end else if (i_ext_en[i]) begin
        o_level[i] = i_ext_val[i];
      end else if (i_pullup[i]) begin
        o_level[i] = 1'b1;
      end else begin
        o_level[i] = float_r[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/fgpio_top_tb.sv
// Purpose: Self-checking bench for the five-pin port block.
// Assumes: Strobe bus, read data in the cycle after the read strobe.
// Notes:   Writes by wr leave one idle cycle so no strobe is set twice at once.
`timescale 1ns/10ps
`default_nettype none
module fgpio_top_tb;
  import fgpio_pkg::*;
  logic               i_clk, i_rst_b, i_wr, i_rd, i_trace_clock_out;
  logic [ADDR_W-1:0]  i_addr;
  logic [DATA_W-1:0]  i_wdata, o_rdata;
  logic [3:0]         i_trace_data_out;
  logic [PIN_CNT-1:0] i_pin, o_pin, o_pin_oe_b, o_pullup_bits;
  logic [PIN_CNT-1:0] o_input_enable_bits, ext_val, ext_en;
  int                 num_errors = 0;
  int                 compares = 0;
  logic [ADDR_W-1:0]  ofs [6] = '{OFS_PIN_DATA, OFS_OUT_EN, OFS_FUNC_SEL,
                                  OFS_OPEN_DRN, OFS_PULLUP_EN, OFS_INPUT_EN};
  logic [PIN_CNT-1:0] pat [6] = '{5'h15, 5'h0a, 5'h13, 5'h0c, 5'h19, 5'h06};

  fgpio_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_trace_clock_out(i_trace_clock_out),
    .i_trace_data_out(i_trace_data_out), .i_pin(i_pin), .o_pin(o_pin),
    .o_pin_oe_b(o_pin_oe_b), .o_pullup_bits(o_pullup_bits),
    .o_input_enable_bits(o_input_enable_bits));

  fgpio_pins_model pads (.i_clk(i_clk), .i_pin_out(o_pin),
    .i_pin_oe_b(o_pin_oe_b), .i_pullup(o_pullup_bits), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_level(i_pin));

  // A 5 ns clock.
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    chk(d, exp);
    @(posedge i_clk);
  endtask

  // Pad flops follow the register one cycle later.
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  // Write then read with no gap, as software may; data one cycle later.
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
    @(posedge i_clk);
  endtask

  // Outputs checked off the edge; registers read only once reset is gone.
  task automatic t_reset();
    #1;
    chk(o_pin_oe_b, 5'h1f);
    chk(o_pullup_bits, 5'h00);
    chk(o_input_enable_bits, 5'h00);
    chk(o_pin, 5'h00);
    chk(o_rdata, 32'h0);
    @(posedge i_clk);
    if (i_rst_b) begin
      for (int i = 0; i < 6; i++) rd(ofs[i], 32'h0);
    end
    $display("reset values done");
  endtask

  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      wr_rd(ofs[i], 32'hffff_ffe0 | pat[i], {27'h0, pat[i]});
    end
    wr(8'h0c, 32'h1f);
    rd(8'h0c, 32'h0);
    rd(8'h3c, 32'h0);
    chk(o_pullup_bits, pat[4]);
    chk(o_input_enable_bits, pat[5]);
    for (int i = 0; i < 6; i++) wr(ofs[i], 32'h0);
    $display("register access done");
  endtask

  task automatic t_drive();
    wr(OFS_OUT_EN, 32'h05);
    wr(OFS_PIN_DATA, 32'h1f);
    settle();
    chk(o_pin_oe_b, 5'h1a);
    chk(o_pin & 5'h05, 5'h05);
    wr(OFS_OPEN_DRN, 32'h04);
    settle();
    chk(o_pin_oe_b, 5'h1e);
    wr(OFS_PIN_DATA, 32'h00);
    settle();
    chk(o_pin_oe_b, 5'h1a);
    chk(o_pin & 5'h05, 5'h00);
    rd(OFS_PIN_DATA, 32'h0);
    wr(OFS_OUT_EN, 32'h0);
    wr(OFS_OPEN_DRN, 32'h0);
    $display("output drive done");
  endtask

  task automatic t_input();
    ext_val <= 5'h14;
    ext_en <= 5'h1c;
    wr(OFS_PULLUP_EN, 32'h03);
    wr(OFS_INPUT_EN, 32'h1f);
    repeat (4) @(posedge i_clk);
    chk(o_pin_oe_b, 5'h1f);
    rd(OFS_PIN_DATA, 32'h17);
    wr(OFS_INPUT_EN, 32'h0);
    rd(OFS_PIN_DATA, 32'h0);
    ext_en <= 5'h00;
    wr(OFS_PULLUP_EN, 32'h0);
    $display("input path done");
  endtask

  task automatic t_trace();
    wr(OFS_FUNC_SEL, 32'h1f);
    settle();
    for (int v = 0; v < 32; v++) begin
      {i_trace_data_out, i_trace_clock_out} <= v[4:0];
      @(posedge i_clk);
      #1;
      chk(o_pin, v[4:0]);
      chk(o_pin_oe_b, 5'h00);
    end
    for (int k = 0; k < 5; k++) begin
      wr(OFS_FUNC_SEL, 32'h1 << k);
      settle();
      chk(o_pin_oe_b, 5'h1f ^ (5'h01 << k));
    end
    wr(OFS_FUNC_SEL, 32'h0);
    $display("trace select done");
  endtask

  // A reset in mid-run returns every pin to quiet port use.
  task automatic t_midrst();
    wr(OFS_OUT_EN, 32'h1f);
    wr(OFS_FUNC_SEL, 32'h03);
    wr(OFS_PULLUP_EN, 32'h1f);
    wr(OFS_INPUT_EN, 32'h1f);
    chk(o_pullup_bits, 5'h1f);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    t_reset();
    i_rst_b <= 1'b1;
    t_reset();
    $display("mid-run reset done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence; reset is held 8 cycles and checked while held.
  initial begin
    {i_rst_b, i_wr, i_rd, i_trace_clock_out} = 4'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_trace_data_out = 4'h0;
    ext_val = 5'h00;
    ext_en = 5'h00;
    repeat (7) @(posedge i_clk);
    t_reset();
    i_rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_drive();
    t_input();
    t_trace();
    t_midrst();
    final_report();
  end

  // A hang is cut short and counted as a mismatch.
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
